// ### tmu_unit.sv
// timer unit top: apb registers, unit reset and clock gate, channel 0 counter
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Operation
// - while the unit reset bit is 1 the whole timer unit is held in reset, and released when it is 0.
// - the unit clock enable bit supplies the unit input clock when 1 and stops it when 0.
// - operation clock zero is the system clock divided by two to the power of prescaler bits 3 to 0.
// - mode bits 15 and 14 pick the channel clock: 00 clock zero, 01 clock two, 10 clock one, 11 clock three.
// - mode bit 12 at 0 counts on the channel clock, at 1 on valid edges of the timer input pin; event counter mode counts pin edges at either value.
// - mode bit 11 at 0 runs channel 0 as a 16-bit timer and at 1 as an 8-bit timer.
// - the mode field codes interval, capture, event counter, one-count and capture plus one-count only.
// - in interval mode the timer interrupt comes every compare value plus one count clock periods.
module tmu_unit
  import tmu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_input_pin,
  input wire logic master_trigger,
  output logic channel_timer_interrupt,
  output logic unit_in_reset,
  output logic unit_clock_on
);

  // bus state
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  // register state
  logic [CTRL_W-1:0] reset_ctrl_q, reset_ctrl_d;
  logic [CTRL_W-1:0] clock_en_q, clock_en_d;
  logic [REG16_W-1:0] prescaler_q, prescaler_d;
  logic [REG16_W-1:0] mode_q, mode_d;
  logic [REG16_W-1:0] compare_q, compare_d;
  // channel state
  tmu_state_t state_q, state_d;
  logic [REG16_W-1:0] cnt_q, cnt_d;
  logic [REG16_W-1:0] capture_q, capture_d;
  logic irq_q, irq_d;
  logic ti_q;
  logic started_q, started_d;

  logic unit_reset_bit;
  logic unit_clock_enable;
  logic unit_run;
  logic unit_wr_ok;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic [OP_CLOCKS-1:0] op_tick;
  logic channel_op_clock;
  logic channel_count_clock;
  logic ti_rise, ti_fall, ti_edge, ti_any;
  logic sw_start, sw_stop, start_trig;
  logic [1:0] op_clock_sel;
  logic count_clock_source;
  logic byte_split_select;
  logic [2:0] start_sel;
  logic [1:0] edge_sel;
  logic [2:0] mode_field;
  logic start_irq;
  logic mode_legal;
  logic [REG16_W-1:0] load_val;
  logic [REG16_W-1:0] width_mask;
  logic cnt_zero;

  assign unit_reset_bit = reset_ctrl_q[UNIT_RESET_BIT_POS];
  assign unit_clock_enable = clock_en_q[UNIT_CLOCK_ENABLE_POS];
  // the unit advances only when clocked and out of reset
  assign unit_run = unit_clock_enable && !unit_reset_bit;
  // without its clock the unit registers cannot take a write, as in a gated block
  assign unit_wr_ok = unit_run;

  assign wr_en = psel && penable && pready_q && pwrite;
  assign rd_setup = psel && !penable;
  assign sw_start = wr_en && (paddr == OFS_CH0_CTRL) && unit_wr_ok && pwdata[CTRL_START_POS];
  assign sw_stop = wr_en && (paddr == OFS_CH0_CTRL) && unit_wr_ok && pwdata[CTRL_STOP_POS];

  // mode field decode
  assign op_clock_sel = {mode_q[OP_CLOCK_SEL_HI_POS], mode_q[OP_CLOCK_SEL_LO_POS]};
  assign count_clock_source = mode_q[COUNT_CLOCK_SOURCE_POS];
  assign byte_split_select = mode_q[BYTE_SPLIT_SELECT_POS];
  assign start_sel = mode_q[START_SEL_LSB+2:START_SEL_LSB];
  assign edge_sel = mode_q[EDGE_SEL_LSB+1:EDGE_SEL_LSB];
  assign mode_field = mode_q[MODE_FIELD_LSB+2:MODE_FIELD_LSB];
  assign start_irq = mode_q[MODE_START_IRQ_POS];

  // shared prescaler for the four operation clocks
  tmu_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .clear(unit_reset_bit),
    .run(unit_run),
    .prescaler_field(prescaler_q),
    .tick(op_tick)
  );

  // operation clock select; note clock two sits on code 01 and clock one on 10
  always_comb
  begin
    channel_op_clock = 1'b0;
    unique case (op_clock_sel)
      2'b00: channel_op_clock = op_tick[0];
      2'b01: channel_op_clock = op_tick[2];
      2'b10: channel_op_clock = op_tick[1];
      2'b11: channel_op_clock = op_tick[3];
    endcase
  end

  // timer input edges; the pin is synchronous so one stage suffices
  assign ti_rise = timer_input_pin && !ti_q;
  assign ti_fall = !timer_input_pin && ti_q;
  assign ti_any = ti_rise || ti_fall;
  assign ti_edge = unit_run && ((edge_sel == EDGE_FALL) ? ti_fall :
                   (edge_sel == EDGE_RISE) ? ti_rise : ti_any);

  // count clock: event mode always counts pin edges
  assign channel_count_clock = unit_run && ((count_clock_source || mode_field == MODE_EVENT) ?
                               ti_edge : channel_op_clock);

  // start sources; master trigger only serves a 16-bit slave
  always_comb
  begin
    start_trig = sw_start;
    if (start_sel == START_TI_EDGE)
      start_trig = sw_start || ti_edge;
    else if (start_sel == START_TI_BOTH)
      start_trig = sw_start || (unit_run && ti_any);
    else if (start_sel == START_MASTER)
      start_trig = sw_start || (unit_run && master_trigger && !byte_split_select);
  end

  // 8-bit operation uses only the low byte of counter and compare value
  assign width_mask = byte_split_select ? 16'h00FF : 16'hFFFF;
  assign load_val = compare_q & width_mask;
  assign cnt_zero = (cnt_q & width_mask) == 16'h0000;

  // prohibited codes leave the channel idle
  always_comb
  begin
    mode_legal = 1'b0;
    case (mode_field)
      MODE_INTERVAL, MODE_CAPTURE, MODE_ONECOUNT: mode_legal = 1'b1;
      MODE_EVENT, MODE_CAPONE: mode_legal = !start_irq;
      default: mode_legal = 1'b0;
    endcase
  end

  // channel counter next state
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    capture_d = capture_q;
    irq_d = 1'b0;
    started_d = started_q;
    if (unit_reset_bit || sw_stop || !mode_legal)
    begin
      state_d = CH_IDLE;
      started_d = 1'b0;
      if (unit_reset_bit)
      begin
        cnt_d = '0;
        capture_d = '0;
      end
    end
    else if (state_q == CH_IDLE)
    begin
      if (start_trig)
      begin
        state_d = CH_RUN;
        started_d = 1'b1;
        // up counters start at zero, down counters at the compare value
        if (mode_field == MODE_CAPTURE || mode_field == MODE_CAPONE)
          cnt_d = '0;
        else
          cnt_d = load_val;
        if (start_irq && (mode_field == MODE_INTERVAL || mode_field == MODE_CAPTURE))
          irq_d = 1'b1;
      end
    end
    else
    begin
      unique case (mode_field)
        MODE_INTERVAL, MODE_EVENT:
        begin
          // reload on zero gives a period of compare plus one ticks
          if (channel_count_clock)
          begin
            if (cnt_zero)
            begin
              cnt_d = load_val;
              irq_d = 1'b1;
            end
            else
              cnt_d = (cnt_q - 16'h0001) & width_mask;
          end
        end
        MODE_CAPTURE:
        begin
          // capture wins over the count tick in the same cycle
          if (ti_edge)
          begin
            capture_d = cnt_q;
            cnt_d = '0;
            irq_d = 1'b1;
          end
          else if (channel_count_clock)
            cnt_d = (cnt_q + 16'h0001) & width_mask;
        end
        MODE_ONECOUNT:
        begin
          // retrigger reloads only when the start-irq bit allows it
          if (start_trig && start_irq)
            cnt_d = load_val;
          else if (channel_count_clock)
          begin
            if (cnt_zero)
            begin
              irq_d = 1'b1;
              state_d = CH_IDLE;
            end
            else
              cnt_d = (cnt_q - 16'h0001) & width_mask;
          end
        end
        MODE_CAPONE:
        begin
          // the edge that started the count cannot also end it
          if (ti_edge && !started_q)
          begin
            capture_d = cnt_q;
            irq_d = 1'b1;
            state_d = CH_IDLE;
          end
          else if (channel_count_clock)
            cnt_d = (cnt_q + 16'h0001) & width_mask;
        end
        default:
          state_d = CH_IDLE;
      endcase
      started_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= CH_IDLE;
      cnt_q <= '0;
      capture_q <= '0;
      irq_q <= 1'b0;
      ti_q <= 1'b0;
      started_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      capture_q <= capture_d;
      irq_q <= irq_d;
      ti_q <= timer_input_pin;
      started_q <= started_d;
    end
  end

  // register writes; unit registers are cleared while the unit is held in reset
  always_comb
  begin
    reset_ctrl_d = reset_ctrl_q;
    clock_en_d = clock_en_q;
    prescaler_d = prescaler_q;
    mode_d = mode_q;
    compare_d = compare_q;
    if (wr_en && paddr == OFS_RESET_CTRL)
      reset_ctrl_d = pwdata[CTRL_W-1:0] & RESET_CTRL_WMASK;
    if (wr_en && paddr == OFS_CLOCK_EN)
      clock_en_d = pwdata[CTRL_W-1:0] & CLOCK_EN_WMASK;
    if (unit_reset_bit)
    begin
      prescaler_d = PRESCALER_RST;
      mode_d = CH0_MODE_RST;
      compare_d = COMPARE_RST;
    end
    else if (wr_en && unit_wr_ok)
    begin
      if (paddr == OFS_PRESCALER)
        prescaler_d = pwdata[REG16_W-1:0] & PRESCALER_WMASK;
      if (paddr == OFS_CH0_MODE)
        mode_d = pwdata[REG16_W-1:0] & CH0_MODE_WMASK;
      if (paddr == OFS_COMPARE)
        compare_d = pwdata[REG16_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_ctrl_q <= RESET_CTRL_RST;
      clock_en_q <= CLOCK_EN_RST;
      prescaler_q <= PRESCALER_RST;
      mode_q <= CH0_MODE_RST;
      compare_q <= COMPARE_RST;
    end
    else
    begin
      reset_ctrl_q <= reset_ctrl_d;
      clock_en_q <= clock_en_d;
      prescaler_q <= prescaler_d;
      mode_q <= mode_d;
      compare_q <= compare_d;
    end
  end

  // address decode shared by read data and error
  always_comb
  begin
    addr_ok = 1'b1;
    prdata_d = 32'h0000_0000;
    unique case (paddr)
      OFS_RESET_CTRL: prdata_d = {24'h000000, reset_ctrl_q};
      OFS_CLOCK_EN: prdata_d = {24'h000000, clock_en_q};
      OFS_PRESCALER: prdata_d = {16'h0000, prescaler_q};
      OFS_CH0_MODE: prdata_d = {16'h0000, mode_q};
      OFS_COMPARE: prdata_d = {16'h0000, compare_q};
      OFS_CH0_CTRL: prdata_d = 32'h0000_0000;
      OFS_CH0_STATUS: prdata_d = {cnt_q, 15'h0000, state_q == CH_RUN};
      OFS_CAPTURE: prdata_d = {16'h0000, capture_q};
      default: addr_ok = 1'b0;
    endcase
  end

  // no wait state: answer is prepared in setup and shown through the access cycle
  always_comb
  begin
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (rd_setup)
    begin
      pready_d = 1'b1;
      pslverr_d = !addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      if (rd_setup)
        prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign channel_timer_interrupt = irq_q;
  assign unit_in_reset = reset_ctrl_q[UNIT_RESET_BIT_POS];
  assign unit_clock_on = clock_en_q[UNIT_CLOCK_ENABLE_POS];

endmodule : tmu_unit

// ### tmu_pkg.sv
// constants, register map and encodings shared by the timer unit files
package tmu_pkg;

  // register byte offsets on the apb slave
  localparam logic [7:0] OFS_RESET_CTRL = 8'h00;
  localparam logic [7:0] OFS_CLOCK_EN = 8'h04;
  localparam logic [7:0] OFS_PRESCALER = 8'h08;
  localparam logic [7:0] OFS_CH0_MODE = 8'h0C;
  localparam logic [7:0] OFS_COMPARE = 8'h10;
  localparam logic [7:0] OFS_CH0_CTRL = 8'h14;
  localparam logic [7:0] OFS_CH0_STATUS = 8'h18;
  localparam logic [7:0] OFS_CAPTURE = 8'h1C;

  // register widths and reset values
  localparam int CTRL_W = 8;
  localparam int REG16_W = 16;
  localparam logic [7:0] RESET_CTRL_RST = 8'h00;
  localparam logic [7:0] CLOCK_EN_RST = 8'h00;
  localparam logic [15:0] PRESCALER_RST = 16'h0000;
  localparam logic [15:0] CH0_MODE_RST = 16'h0000;
  localparam logic [15:0] COMPARE_RST = 16'h0000;

  // writable bits; the rest read as zero
  localparam logic [7:0] RESET_CTRL_WMASK = 8'h01;
  localparam logic [7:0] CLOCK_EN_WMASK = 8'h01;
  localparam logic [15:0] PRESCALER_WMASK = 16'h33FF;
  localparam logic [15:0] CH0_MODE_WMASK = 16'hDFCF;

  // field positions
  localparam int UNIT_RESET_BIT_POS = 0;
  localparam int UNIT_CLOCK_ENABLE_POS = 0;
  localparam int OP_CLOCK_SEL_HI_POS = 15;
  localparam int OP_CLOCK_SEL_LO_POS = 14;
  localparam int COUNT_CLOCK_SOURCE_POS = 12;
  localparam int BYTE_SPLIT_SELECT_POS = 11;
  localparam int START_SEL_LSB = 8;
  localparam int EDGE_SEL_LSB = 6;
  localparam int MODE_FIELD_LSB = 1;
  localparam int MODE_START_IRQ_POS = 0;
  localparam int CTRL_START_POS = 0;
  localparam int CTRL_STOP_POS = 1;

  // prescaler field layout and divider length
  localparam int PRESCALE_CNT_W = 15;
  localparam int OP_CLOCKS = 4;
  localparam logic [3:0] CK2_EXP_BASE = 4'h2;
  localparam logic [3:0] CK3_EXP_BASE = 4'h8;

  // channel modes held in the three upper bits of the mode field
  typedef enum logic [2:0] {
    MODE_INTERVAL = 3'b000,
    MODE_CAPTURE = 3'b010,
    MODE_EVENT = 3'b011,
    MODE_ONECOUNT = 3'b100,
    MODE_CAPONE = 3'b110
  } tmu_mode_t;

  // start trigger sources
  localparam logic [2:0] START_SW = 3'b000;
  localparam logic [2:0] START_TI_EDGE = 3'b001;
  localparam logic [2:0] START_TI_BOTH = 3'b010;
  localparam logic [2:0] START_MASTER = 3'b100;

  // timer input valid edge choices
  localparam logic [1:0] EDGE_FALL = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;

  // channel run state
  typedef enum logic {
    CH_IDLE = 1'b0,
    CH_RUN = 1'b1
  } tmu_state_t;

endpackage : tmu_pkg

// ### tmu_prescaler.sv
// prescaler deriving four operation clock enables from the system clock
`timescale 1ns/10ps
module tmu_prescaler
  import tmu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic run,
  input wire logic [tmu_pkg::REG16_W-1:0] prescaler_field,
  output logic [tmu_pkg::OP_CLOCKS-1:0] tick
);

  logic [PRESCALE_CNT_W-1:0] cnt_q;
  logic [PRESCALE_CNT_W-1:0] cnt_d;
  logic [3:0] exp_sel [OP_CLOCKS];

  // exponents: clock zero and one take full 4-bit fields, two and three take 2-bit fields
  assign exp_sel[0] = prescaler_field[3:0];
  assign exp_sel[1] = prescaler_field[7:4];
  assign exp_sel[2] = 4'({1'b0, prescaler_field[9:8], 1'b0} + CK2_EXP_BASE);
  assign exp_sel[3] = 4'({1'b0, prescaler_field[13:12], 1'b0} + CK3_EXP_BASE);

  // one shared free counter; a tap ticks when its low n bits are all ones
  genvar gi;
  generate
    for (gi = 0; gi < OP_CLOCKS; gi++)
    begin : g_tap
      logic [PRESCALE_CNT_W-1:0] mask;
      assign mask = (15'h0001 << exp_sel[gi]) - 15'h0001;
      assign tick[gi] = run && ((cnt_q & mask) == mask);
    end
  endgenerate

  // counter stops with the clock gate and restarts from zero on unit reset
  always_comb
  begin
    cnt_d = cnt_q;
    if (clear)
      cnt_d = '0;
    else if (run)
      cnt_d = cnt_q + 15'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

endmodule : tmu_prescaler

// ### tmu_unit_sva.sv
// assertion checker on the timer unit ports
`timescale 1ns/10ps
module tmu_unit_sva
  import tmu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_input_pin,
  input wire logic master_trigger,
  input wire logic channel_timer_interrupt,
  input wire logic unit_in_reset,
  input wire logic unit_clock_on
);
  logic wr_rst;
  logic wr_clk;
  logic setup;
  // completed writes to the two always-open control registers
  assign wr_rst = psel && penable && pready && pwrite && paddr == OFS_RESET_CTRL;
  assign wr_clk = psel && penable && pready && pwrite && paddr == OFS_CLOCK_EN;
  assign setup = psel && !penable;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  setup_answer_a: assert property (setup |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  mapped_ok_a: assert property (setup && paddr <= OFS_CAPTURE && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("error on mapped offset");
  unmapped_err_a: assert property (setup && paddr > OFS_CAPTURE |=> pslverr)
    else $error("no error on unmapped offset");
  rst_bit_set_a: assert property (wr_rst |=> unit_in_reset == $past(pwdata[0]))
    else $error("reset bit not written");
  rst_bit_keep_a: assert property (!wr_rst |=> $stable(unit_in_reset))
    else $error("reset bit moved");
  clk_bit_set_a: assert property (wr_clk |=> unit_clock_on == $past(pwdata[0]))
    else $error("clock bit not written");
  clk_bit_keep_a: assert property (!wr_clk |=> $stable(unit_clock_on))
    else $error("clock bit moved");
  reset_quiet_a: assert property (unit_in_reset [*2] |-> !channel_timer_interrupt)
    else $error("interrupt in unit reset");
  gate_quiet_a: assert property (!unit_clock_on [*3] |-> !channel_timer_interrupt)
    else $error("interrupt with clock stopped");
  // main scenarios reached
  irq_seen_c: cover property (channel_timer_interrupt);
  err_seen_c: cover property (pslverr);
  rst_set_c: cover property (wr_rst && pwdata[0]);
endmodule : tmu_unit_sva

bind tmu_unit tmu_unit_sva tmu_unit_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_input_pin(timer_input_pin),
  .master_trigger(master_trigger), .channel_timer_interrupt(channel_timer_interrupt),
  .unit_in_reset(unit_in_reset), .unit_clock_on(unit_clock_on));

// ### tmu_pin_model.sv
// model of the external source on the timer input pin
`timescale 1ns/10ps
module tmu_pin_model #(
  parameter int GAP = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic pin
);
  logic [7:0] cnt_q;
  // toggles every GAP cycles while run; stands at its level otherwise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 8'h00;
      pin <= 1'b0;
    end
    else if (run)
    begin
      cnt_q <= (cnt_q == 8'(GAP - 1)) ? 8'h00 : cnt_q + 8'h01;
      if (cnt_q == 8'(GAP - 1))
        pin <= ~pin;
    end
  end
endmodule : tmu_pin_model

// ### tmu_unit_test.sv
// self-checking testbench for the timer unit
`timescale 1ns/10ps
module tmu_unit_test;
  import tmu_pkg::*;
  typedef struct {logic [15:0] prescaler_field; logic [15:0] mode; logic [15:0] cmp; logic ti; int per;} tmu_row_t;
  logic pclk, presetn, psel, penable, pwrite, master_trigger, pin_run, err;
  logic pready, pslverr, timer_input_pin, channel_timer_interrupt, unit_in_reset, unit_clock_on;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] masks [4];
  logic [15:0] modes [9];
  logic [8:0] runs;
  int fail_count, compares, cyc, irq_n, n, t0;
  tmu_row_t rows [8];
  tmu_unit tmu_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_input_pin(timer_input_pin), .master_trigger(master_trigger),
    .channel_timer_interrupt(channel_timer_interrupt), .unit_in_reset(unit_in_reset),
    .unit_clock_on(unit_clock_on));
  tmu_pin_model #(.GAP(5)) tmu_pin_model_i (.pclk(pclk), .presetn(presetn), .run(pin_run),
    .pin(timer_input_pin));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // cycle and interrupt counters used to time periods
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (channel_timer_interrupt === 1'b1)
      irq_n <= irq_n + 1;
  end
  task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // one apb transfer; request held until ready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // ready, read data and error are all taken at the edge that completes the access
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fail_count++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_irq(input int bound);
    int m;
    #1;
    m = irq_n;
    for (n = 0; n < bound && irq_n == m; n++)
    begin
      @(posedge pclk);
      #1;
    end
    if (n == bound)
    begin
      fail_count++;
      test_done();
    end
  endtask : wait_irq
  task quiet(input int cycles);
    int m;
    // an interrupt launched at the edge where the write lands is still legal
    repeat (2) @(posedge pclk);
    #1;
    m = irq_n;
    repeat (cycles) @(posedge pclk);
    #1;
    chk("no interrupt", 32'(irq_n), 32'(m));
  endtask : quiet
  initial
  begin
    {psel, penable, pwrite, master_trigger, pin_run, err} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    rd = 32'h0;
    presetn = 1'b0;
    {fail_count, compares, cyc, irq_n} = {32'h0, 32'h0, 32'h0, 32'h0};
    masks = '{32'h01, 32'h01, 32'h33FF, 32'hDFCF};
    // interval periods: prescaler, clock choice, split, pin edges
    rows[0] = '{16'h0000, 16'h0000, 16'h0003, 1'b0, 4};
    rows[1] = '{16'h0002, 16'h0000, 16'h0003, 1'b0, 16};
    rows[2] = '{16'h000F, 16'h0000, 16'h0000, 1'b0, 32768};
    rows[3] = '{16'h0020, 16'h8000, 16'h0001, 1'b0, 8};
    rows[4] = '{16'h0100, 16'h4000, 16'h0001, 1'b0, 32};
    rows[5] = '{16'h0000, 16'hC000, 16'h0000, 1'b0, 256};
    rows[6] = '{16'h0000, 16'h0800, 16'h0103, 1'b0, 4};
    rows[7] = '{16'h0000, 16'h1040, 16'h0001, 1'b1, 20};
    modes = '{16'h0000, 16'h0004, 16'h0006, 16'h0008, 16'h000C, 16'h000A, 16'h000E, 16'h0400, 16'h0C00};
    runs = 9'h09F;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", rd, 32'h0);
    end
    apb(1'b1, OFS_PRESCALER, 32'hFFFF);
    apb(1'b1, OFS_CLOCK_EN, 32'h1);
    apb(1'b0, OFS_PRESCALER, 32'h0);
    chk("gated write", rd, 32'h0);
    for (int i = 3; i >= 0; i--)
    begin
      apb(1'b1, 8'(4 * i), 32'hFFFFFFFF);
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("mask", rd, masks[i]);
    end
    apb(1'b0, OFS_CH0_MODE, 32'h0);
    chk("mode in reset", rd, 32'h0);
    apb(1'b1, OFS_RESET_CTRL, 32'h0);
    apb(1'b1, 8'h40, 32'h5);
    chk("unmapped error", 32'(err), 32'h1);
    $display("test registers done");
    foreach (rows[i])
    begin
      apb(1'b1, OFS_PRESCALER, 32'(rows[i].prescaler_field));
      apb(1'b1, OFS_CH0_MODE, 32'(rows[i].mode));
      apb(1'b1, OFS_COMPARE, 32'(rows[i].cmp));
      pin_run <= rows[i].ti;
      apb(1'b1, OFS_CH0_CTRL, 32'h1);
      wait_irq(70000);
      t0 = cyc;
      wait_irq(70000);
      chk("period", 32'(cyc - t0), 32'(rows[i].per));
      apb(1'b1, OFS_CH0_CTRL, 32'h2);
      pin_run <= 1'b0;
      $display("test period row %0d done", i);
    end
    // mode codes, then slave start by master pulse in 16 and 8 bit
    foreach (modes[i])
    begin
      apb(1'b1, OFS_CH0_MODE, 32'(modes[i]));
      apb(1'b1, OFS_COMPARE, 32'hFF);
      if (i < 7)
        apb(1'b1, OFS_CH0_CTRL, 32'h1);
      else
      begin
        @(posedge pclk);
        master_trigger <= 1'b1;
        @(posedge pclk);
        master_trigger <= 1'b0;
      end
      apb(1'b0, OFS_CH0_STATUS, 32'h0);
      chk("running", 32'(rd[0]), 32'(runs[i]));
      apb(1'b1, OFS_CH0_CTRL, 32'h2);
    end
    $display("test modes done");
    apb(1'b1, OFS_PRESCALER, 32'h0);
    apb(1'b1, OFS_CH0_MODE, 32'h0);
    apb(1'b1, OFS_COMPARE, 32'h3);
    apb(1'b1, OFS_CH0_CTRL, 32'h1);
    wait_irq(50);
    apb(1'b1, OFS_CLOCK_EN, 32'h0);
    quiet(20);
    chk("clock flag", 32'(unit_clock_on), 32'h0);
    apb(1'b1, OFS_CLOCK_EN, 32'h1);
    wait_irq(20);
    apb(1'b1, OFS_RESET_CTRL, 32'h1);
    quiet(20);
    chk("reset flag", 32'(unit_in_reset), 32'h1);
    apb(1'b0, OFS_COMPARE, 32'h0);
    chk("compare in reset", rd, 32'h0);
    apb(1'b1, OFS_RESET_CTRL, 32'h0);
    apb(1'b0, OFS_CH0_STATUS, 32'h0);
    chk("idle after reset", 32'(rd[0]), 32'h0);
    $display("test gate and reset done");
    test_done();
  end
endmodule : tmu_unit_test
